/* File: verilog/key_timers_map.vh */
// Constants for the key repeat and bell timer block
`ifndef KEY_TIMERS_MAP_VH
`define KEY_TIMERS_MAP_VH
`define CNT_W 16
`define PROC_CLK_HZ 7372800
`define XTAL_HZ 14745600
`define REF_CLK_HZ 200000000
`define INIT_DELAY_MS 16'h01f4
`define REPEAT_MS 16'h0064
`define FAST_REPEAT_MS 16'h000a
`define BELL_MS 16'h0064
`define MS_TICK_COUNT 16'h1ccd
`define TICK_DIV_RESET 16'h0000
`endif

/* File: verilog/prog_timer.v */
// One sixteen-bit programmable timer with terminal count pulse
`timescale 1ns/100ps
`default_nettype none
`include "key_timers_map.vh"
module prog_timer #(
  parameter W = `CNT_W
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_ce,
  // Control
  input wire i_tick,
  input wire i_run,
  input wire i_reload,
  input wire [W-1:0] i_max,
  // Status
  output reg o_done,
  output reg [W-1:0] o_count
);
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_count <= {W{1'b0}};
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (i_reload || !i_run) begin
        o_count <= {W{1'b0}};
      end else if (i_tick) begin
        if (o_count >= i_max - 1'b1) begin
          o_count <= {W{1'b0}};
          o_done <= 1'b1;
        end else begin
          o_count <= o_count + 1'b1;
        end
      end
    end
  end
endmodule // prog_timer
`default_nettype wire

/* File: verilog/key_repeat_bell_timers.v */
// Bell and key repeat timers driven from a divided processor clock
// How it works
// RULE1 - Three independent sixteen-bit timers, each with its own enable, run here.
// RULE2 - Timer zero times the bell and drives the bell output.
// RULE3 - Timers one and two detect the key press and measure how long it is held.
// RULE4 - No repeat comes until the key has been held for 500 ms.
// RULE5 - After that delay the key repeats every 100 ms while held.
// RULE6 - With Shift also held the repeat interval is 10 ms.
// RULE7 - Timers count ticks of a 7.3728 MHz processor clock, the 14.7456 MHz crystal halved.
// RULE8 - A timer request reaches the interrupt line only if its own enable and its mask allow it.
// RULE9 - Release stops repeating at once and clears the hold measure.
`timescale 1ns/100ps
`default_nettype none
`include "key_timers_map.vh"
module key_repeat_bell_timers #(
  parameter W = `CNT_W,
  parameter [W-1:0] MS_TICKS = `MS_TICK_COUNT,
  parameter [W-1:0] INIT_MS = `INIT_DELAY_MS,
  parameter [W-1:0] REP_MS = `REPEAT_MS,
  parameter [W-1:0] FAST_MS = `FAST_REPEAT_MS,
  parameter [W-1:0] BELL_LEN_MS = `BELL_MS
) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_ce,
  // Keyboard and bell request pins
  input wire i_key_down,
  input wire i_shift_down,
  input wire i_bell_req,
  // Per-timer enables and interrupt masks, bit n for timer n
  input wire [2:0] i_tmr_en,
  input wire [2:0] i_irq_mask,
  // Outputs
  output reg o_bell,
  output reg o_key_strobe,
  output reg [2:0] o_irq_req,
  output reg o_irq
);
  // Processor clock tick: phase accumulator, 200 MHz to 7.3728 MHz
  localparam [31:0] PH_INC = 32'd158329674; // 2^32 * 7.3728 / 200, rounded
  // Average rate is off only by the rounding of PH_INC; single ticks jitter by one reference cycle
  reg [31:0] ph_q;
  reg [32:0] ph_sum;
  reg tick_q;
  always @* begin
    ph_sum = {1'b0, ph_q} + {1'b0, PH_INC};
  end
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ph_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      ph_q <= ph_sum[31:0];
      tick_q <= ph_sum[32]; // [RULE7]
    end
  end

  // Millisecond prescale shared by all timers
  reg [W-1:0] ms_cnt_q;
  reg ms_q;
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ms_cnt_q <= {W{1'b0}};
      ms_q <= 1'b0;
    end else if (i_ce) begin
      ms_q <= 1'b0;
      if (tick_q) begin
        if (ms_cnt_q >= MS_TICKS - 1'b1) begin
          ms_cnt_q <= {W{1'b0}};
          ms_q <= 1'b1;
        end else begin
          ms_cnt_q <= ms_cnt_q + 1'b1;
        end
      end
    end
  end

  // Pin synchronisers
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else if (i_ce) begin
      sync1_q <= {i_bell_req, i_shift_down, i_key_down};
      sync2_q <= sync1_q;
    end
  end
  wire key_s = sync2_q[0];
  wire shift_s = sync2_q[1];
  wire bell_s = sync2_q[2];
  reg key_prev_q;
  reg bell_prev_q;
  wire key_press = key_s & ~key_prev_q;
  wire bell_start = bell_s & ~bell_prev_q;

  // Repeat state
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_HOLD = 2'd1;
  localparam [1:0] ST_REP = 2'd2;
  reg [1:0] state_q;
  reg bell_on_q;

  wire [2:0] done;
  wire [W-1:0] cnt0;
  wire [W-1:0] cnt1;
  wire [W-1:0] cnt2;
  // Shift is read live, so it takes effect within the interval in progress
  wire [W-1:0] rep_max = shift_s ? FAST_MS : REP_MS; // [RULE6]

  // Timer 0: bell length
  prog_timer #(.W(W)) u_tmr0 (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_tick(ms_q),
    .i_run(bell_on_q & i_tmr_en[0]),
    .i_reload(bell_start),
    .i_max(BELL_LEN_MS),
    .o_done(done[0]),
    .o_count(cnt0)
  ); // [RULE1] [RULE2]
  // Timer 1: initial hold delay
  prog_timer #(.W(W)) u_tmr1 (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_tick(ms_q),
    .i_run(key_s & (state_q == ST_HOLD) & i_tmr_en[1]),
    .i_reload(key_press),
    .i_max(INIT_MS),
    .o_done(done[1]),
    .o_count(cnt1)
  ); // [RULE1] [RULE3] [RULE4]
  // Timer 2: repeat interval
  // Held at zero outside the repeat state, so it needs no reload
  prog_timer #(.W(W)) u_tmr2 (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_tick(ms_q),
    .i_run(key_s & (state_q == ST_REP) & i_tmr_en[2]),
    .i_reload(1'b0),
    .i_max(rep_max),
    .o_done(done[2]),
    .o_count(cnt2)
  ); // [RULE1] [RULE3] [RULE5]

  // Edge detectors; reset matches the idle pin level, so no false edge
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      key_prev_q <= 1'b0;
      bell_prev_q <= 1'b0;
    end else if (i_ce) begin
      key_prev_q <= key_s;
      bell_prev_q <= bell_s;
    end
  end

  // Bell sounds until timer zero expires; a new request restarts it
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      bell_on_q <= 1'b0;
      o_bell <= 1'b0;
    end else if (i_ce) begin
      if (bell_start && i_tmr_en[0]) begin
        bell_on_q <= 1'b1;
      end else if (done[0] || !i_tmr_en[0]) begin
        bell_on_q <= 1'b0;
      end
      o_bell <= bell_on_q; // [RULE2]
    end
  end

  // Key repeat sequencer; the press itself issues the first character
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      o_key_strobe <= 1'b0;
    end else if (i_ce) begin
      o_key_strobe <= 1'b0;
      if (!key_s) begin
        state_q <= ST_IDLE; // [RULE9]
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (key_press) begin
              state_q <= ST_HOLD;
              o_key_strobe <= 1'b1;
            end
          end
          ST_HOLD: begin
            if (done[1]) begin
              state_q <= ST_REP; // [RULE4]
              o_key_strobe <= 1'b1;
            end
          end
          ST_REP: begin
            if (done[2]) begin
              o_key_strobe <= 1'b1; // [RULE5]
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Request stays raised until the timer is disabled, so a late service
  // loses nothing; the mask only hides it from the interrupt line
  always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_irq_req <= 3'h0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq_req <= (o_irq_req | (done & i_tmr_en)) & i_tmr_en; // [RULE8]
      o_irq <= |(o_irq_req & i_tmr_en & ~i_irq_mask); // [RULE8]
    end
  end
endmodule // key_repeat_bell_timers
`default_nettype wire

/* File: dv/key_repeat_bell_timers_assertions.sv */
// Port checker for the key repeat and bell timers
`timescale 1ns/100ps
`default_nettype none
module krbt_chk (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Pins and controls
  input wire logic i_key_down,
  input wire logic i_bell_req,
  input wire logic [2:0] i_tmr_en,
  input wire logic [2:0] i_irq_mask,
  // Outputs
  input wire logic o_bell,
  input wire logic o_key_strobe,
  input wire logic [2:0] o_irq_req,
  input wire logic o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [10:0] held_q;
  // Cycles the key pin has been high
  always @(posedge i_ref_clk) if (i_ce) held_q <= i_key_down ? held_q + 11'h001 : 11'h000;
  sequence s_rel; !i_key_down [*5]; endsequence
  sequence s_bell_go; $rose(i_bell_req) && i_tmr_en[0]; endsequence
  a_press_strobe: assert property (held_q == 11'h001 |-> ##[1:4] o_key_strobe)
    else $error("no strobe on key press");
  a_no_early_rep: assert property (o_key_strobe |-> held_q < 11'h00a || held_q > 11'h0be)
    else $error("repeat before initial delay");
  a_strobe_pulse: assert property (o_key_strobe |=> !o_key_strobe)
    else $error("strobe longer than one cycle");
  a_release_quiet: assert property (s_rel |-> !o_key_strobe)
    else $error("strobe after release");
  a_bell_start: assert property (s_bell_go |-> ##[2:5] o_bell)
    else $error("bell did not start");
  a_bell_length: assert property ($rose(o_bell) |-> o_bell [*8])
    else $error("bell too short");
  a_bell_gated: assert property (!i_tmr_en[0] && !o_bell |=> !o_bell)
    else $error("bell while timer disabled");
  a_irq_gate: assert property (i_ce |=> o_irq ==
    |$past(o_irq_req & i_tmr_en & ~i_irq_mask))
    else $error("interrupt gating wrong");
endmodule // krbt_chk
bind key_repeat_bell_timers krbt_chk u_krbt_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_key_down(i_key_down), .i_bell_req(i_bell_req), .i_tmr_en(i_tmr_en),
  .i_irq_mask(i_irq_mask), .o_bell(o_bell), .o_key_strobe(o_key_strobe),
  .o_irq_req(o_irq_req), .o_irq(o_irq));
`default_nettype wire

/* File: dv/key_pad_model.sv */
// Keyboard pins and bell sounder stand-in
`timescale 1ns/100ps
`default_nettype none
module key_pad_model (
  // Clock and bell
  input wire logic i_ref_clk,
  input wire logic i_bell,
  // Pins to the timers
  output var logic o_key,
  output var logic o_shift,
  output var logic o_ring,
  output var int o_bell_len
);
  initial begin
    o_key = 1'b0;
    o_shift = 1'b0;
    o_ring = 1'b0;
  end
  // Sounder on time, in cycles
  always @(posedge i_ref_clk) o_bell_len <= o_bell_len + (i_bell ? 1 : 0);
  task automatic hold(input int n, input logic sh);
    @(negedge i_ref_clk);
    o_key = 1'b1;
    o_shift = sh;
    repeat (n) @(negedge i_ref_clk);
    o_key = 1'b0;
    o_shift = 1'b0;
    repeat (40) @(negedge i_ref_clk);
  endtask
  task automatic ring;
    @(negedge i_ref_clk);
    o_ring = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    o_ring = 1'b0;
    repeat (300) @(negedge i_ref_clk);
  endtask
endmodule // key_pad_model
`default_nettype wire

/* File: dv/key_repeat_bell_timers_test.sv */
// Bench for the key repeat and bell timers
`timescale 1ns/100ps
`default_nettype none
module key_repeat_bell_timers_test;
  // One ms is 2 ticks of 7.3728 MHz at 200 MHz
  localparam int MS = 2 * 200000 / 7373;
  logic i_ref_clk, i_rst_n, i_ce, key, shift, ring, o_bell, o_key_strobe, o_irq;
  logic [2:0] i_tmr_en, i_irq_mask, o_irq_req;
  int bell_len, n_errors, num_checks, cyc, b0;
  int st[$];
  key_repeat_bell_timers #(.MS_TICKS(16'd2), .INIT_MS(16'd5), .REP_MS(16'd3),
    .FAST_MS(16'd1), .BELL_LEN_MS(16'd4)) u_key_repeat_bell_timers (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_key_down(key), .i_shift_down(shift),
    .i_bell_req(ring), .i_tmr_en(i_tmr_en), .i_irq_mask(i_irq_mask), .o_bell(o_bell),
    .o_key_strobe(o_key_strobe), .o_irq_req(o_irq_req), .o_irq(o_irq));
  key_pad_model u_key_pad_model (.i_ref_clk(i_ref_clk), .i_bell(o_bell), .o_key(key),
    .o_shift(shift), .o_ring(ring), .o_bell_len(bell_len));
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_key_strobe === 1'b1) st.push_back(cyc);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    num_checks++;
    if ($isunknown(got) || (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp))) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Model: press strobe, then one after the delay, then one per interval
  task automatic key_case(input int n, input logic sh, input logic rep);
    int r;
    r = (sh ? 1 : 3) * MS;
    st.delete();
    u_key_pad_model.hold(n, sh);
    chk(st.size(), !rep || n < 5 * MS ? 1 : 2 + (n - 5 * MS) / r, rep);
    for (int i = 1; i < st.size(); i++) chk(st[i] - st[i-1], i == 1 ? 5 * MS : r, 60);
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_errors++;
    final_report();
  end
  initial begin
    void'($urandom(62));
    {n_errors, num_checks, cyc} = 0;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_tmr_en = 3'h7;
    i_irq_mask = 3'h0;
    repeat (4) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    chk({o_bell, o_key_strobe, o_irq_req, o_irq}, 0, 0);
    for (int k = 0; k < 4; k++) key_case(120 + $urandom_range(700), k[0], 1'b1);
    key_case(700, 1'b0, 1'b1);
    chk(o_irq_req, 3'h6, 0);
    chk(o_irq, 1'b1, 0);
    i_tmr_en = 3'h5;
    key_case(600, 1'b0, 1'b0);
    chk(o_irq_req, 3'h4, 0);
    i_tmr_en = 3'h1;
    b0 = bell_len;
    u_key_pad_model.ring();
    chk(bell_len - b0, 4 * MS, 60);
    chk(o_irq_req, 3'h1, 0);
    chk(o_irq, 1'b1, 0);
    i_irq_mask = 3'h1;
    repeat (2) @(negedge i_ref_clk);
    chk(o_irq, 1'b0, 0);
    // Clock enable low mid-bell must stretch the bell by the frozen span
    b0 = bell_len;
    fork
      u_key_pad_model.ring();
      begin
        repeat (60) @(negedge i_ref_clk);
        i_ce = 1'b0;
        repeat (100) @(negedge i_ref_clk);
        i_ce = 1'b1;
      end
    join
    repeat (40) @(negedge i_ref_clk);
    chk(bell_len - b0, 4 * MS + 100, 60);
    i_tmr_en = 3'h6;
    b0 = bell_len;
    u_key_pad_model.ring();
    chk(bell_len - b0, 0, 0);
    final_report();
  end
endmodule // key_repeat_bell_timers_test
`default_nettype wire
